// ===== logic/hbp_pkg.sv
package hbp_pkg;
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned CLK_PERIOD_NS = 4;
   // Times in their own unit, as specified.
   localparam int unsigned BLANK_US = 5;
   localparam int unsigned LIMIT_OFF_US = 35;
   localparam int unsigned GUARD_OFF_US = 135;
   localparam int unsigned DIAG_TOGGLE_KHZ = 90;
   localparam int unsigned FILT_NS = 200;
   // Derived cycle counts.
   localparam int unsigned BLANK_CYC = BLANK_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned LIMIT_OFF_CYC = LIMIT_OFF_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned GUARD_OFF_CYC = GUARD_OFF_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned DIAG_HALF_CYC = CLK_HZ / (DIAG_TOGGLE_KHZ * 1000 * 2);
   localparam int unsigned FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 17;
   localparam int unsigned FILT_W = 8;
   localparam logic [1:0] SYNC_RST = 2'h0;

   typedef enum logic [1:0] {
      HBP_RUN = 2'b00,
      HBP_BLANK = 2'b01,
      HBP_LIMIT_OFF = 2'b11,
      HBP_GUARD_OFF = 2'b10
   } hbp_state_t;

   typedef enum logic [1:0] {
      HBP_COAST = 2'b00,
      HBP_FWD = 2'b01,
      HBP_REV = 2'b10,
      HBP_BRAKE = 2'b11
   } hbp_cmd_t;
endpackage

// ===== logic/hbp_in_filter.sv
`timescale 1ns/10ps
`default_nettype none
module hbp_in_filter
   import hbp_pkg::*;
(
   input wire logic clk_i, // Clock.
   input wire logic rst_n_i, // Synchronised reset, active low.
   input wire logic pin_i, // Asynchronous input pin.
   output logic filt_o // Synchronised and filtered level.
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic [FILT_W-1:0] cnt_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A level must stay for the whole filter time before it is taken, so short glitches vanish.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= '0;
         filt_o <= 1'b0;
      end else if (s2_r != s3_r || s3_r == filt_o) begin
         cnt_r <= '0;
      end else if (cnt_r == FILT_W'(FILT_CYC - 1)) begin
         cnt_r <= '0;
         filt_o <= s3_r;
      end else begin
         cnt_r <= cnt_r + FILT_W'(1);
      end
   end
endmodule
`default_nettype wire

// ===== logic/hbp_flag_sync.sv
`timescale 1ns/10ps
`default_nettype none
module hbp_flag_sync
   import hbp_pkg::*;
(
   input wire logic clk_i, // Clock.
   input wire logic rst_n_i, // Synchronised reset, active low.
   input wire logic flag_i, // Asynchronous comparator flag.
   output logic flag_o // Stable flag level.
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         flag_o <= 1'b0;
      end else begin
         s1_r <= flag_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            flag_o <= s3_r;
         end
      end
   end
endmodule
`default_nettype wire

// ===== logic/hbp_bridge_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Pulsed input picks direction, steady input decay.
// - Steady low gives synchronous rectified decay; the code coasts with all switches off instead.
// - Overcurrent flag triggers the overcurrent guard.
// - Guard turns all switches off 135 us.
// - Guard auto-recovers, diagnostic low meanwhile.
// - Limit below guard: guard only during blanking.
// - Guard below limit: guard acts any time; the code acts only while forward or reverse is driven, or in limit off.
// - Thermal cutout disables outputs, recovers with hysteresis.
// - Diagnostic low during thermal cutout.
// - Any supply lockout flag disables the bridge.
// - Steady inputs decode coast, forward, reverse, brake.
// - 5 us blanking, then 35 us high-side off.
// - Diagnostic high, toggling in limit-off, low on fault.
module hbp_bridge_ctrl
   import hbp_pkg::*;
(
   input wire logic CLK_I, // 250 MHz clock.
   input wire logic ARST_N_I, // Asynchronous reset, active low.
   input wire logic DIR_INPUT_A_I, // Direction input A pin.
   input wire logic DIR_INPUT_B_I, // Direction input B pin.
   input wire logic LIMIT_CMP_I, // Sense voltage reached limit_set_voltage.
   input wire logic OVERCURRENT_CMP_I, // Sense voltage reached overcurrent_set_voltage.
   input wire logic GUARD_BELOW_LIMIT_I, // Overcurrent reference is below the limit reference.
   input wire logic THERMAL_ON_I, // Thermal cutout activation flag.
   input wire logic THERMAL_OFF_I, // Thermal cutout release flag (cooled).
   input wire logic LOCKOUT_MAIN_I, // Main supply undervoltage flag.
   input wire logic LOCKOUT_LOGIC_I, // Logic supply undervoltage flag.
   input wire logic LOCKOUT_PUMP_I, // Charge pump undervoltage flag.
   output logic BRIDGE_OUT_A_HI_O, // Side A high-side switch on.
   output logic BRIDGE_OUT_A_LO_O, // Side A low-side switch on.
   output logic BRIDGE_OUT_B_HI_O, // Side B high-side switch on.
   output logic BRIDGE_OUT_B_LO_O, // Side B low-side switch on.
   output logic DIAG_O // Diagnostic output.
);
   logic rst1_r;
   logic rst_n;
   logic dir_a;
   logic dir_b;
   logic limit_f;
   logic guard_f;
   logic guard_below_f;
   logic therm_on_f;
   logic therm_off_f;
   logic lock_main_f;
   logic lock_logic_f;
   logic lock_pump_f;
   logic lockout;
   logic thermal_cutout_r;
   hbp_state_t state_r;
   hbp_state_t state_nxt;
   logic [CNT_W-1:0] tmr_r;
   logic [CNT_W-1:0] guard_len_r;
   logic [CNT_W-1:0] diag_cnt_r;
   logic diag_tgl_r;
   hbp_cmd_t cmd;
   hbp_cmd_t cmd_prev_r;
   logic drive_on;
   logic turn_on;
   logic guard_hit;
   logic tmr_done;
   logic [3:0] sw_nxt;

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rst1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst1_r <= 1'b1;
         rst_n <= rst1_r;
      end
   end

   hbp_in_filter u_filt_a (
      .clk_i(CLK_I),
      .rst_n_i(rst_n),
      .pin_i(DIR_INPUT_A_I),
      .filt_o(dir_a)
   );
   hbp_in_filter u_filt_b (
      .clk_i(CLK_I),
      .rst_n_i(rst_n),
      .pin_i(DIR_INPUT_B_I),
      .filt_o(dir_b)
   );

   hbp_flag_sync u_s_lim (.clk_i(CLK_I), .rst_n_i(rst_n), .flag_i(LIMIT_CMP_I), .flag_o(limit_f));
   hbp_flag_sync u_s_oc (.clk_i(CLK_I), .rst_n_i(rst_n), .flag_i(OVERCURRENT_CMP_I),
      .flag_o(guard_f));
   hbp_flag_sync u_s_gb (.clk_i(CLK_I), .rst_n_i(rst_n), .flag_i(GUARD_BELOW_LIMIT_I),
      .flag_o(guard_below_f));
   hbp_flag_sync u_s_ton (.clk_i(CLK_I), .rst_n_i(rst_n), .flag_i(THERMAL_ON_I),
      .flag_o(therm_on_f));
   hbp_flag_sync u_s_toff (.clk_i(CLK_I), .rst_n_i(rst_n), .flag_i(THERMAL_OFF_I),
      .flag_o(therm_off_f));
   hbp_flag_sync u_s_lm (.clk_i(CLK_I), .rst_n_i(rst_n), .flag_i(LOCKOUT_MAIN_I),
      .flag_o(lock_main_f));
   hbp_flag_sync u_s_ll (.clk_i(CLK_I), .rst_n_i(rst_n), .flag_i(LOCKOUT_LOGIC_I),
      .flag_o(lock_logic_f));
   hbp_flag_sync u_s_lp (.clk_i(CLK_I), .rst_n_i(rst_n), .flag_i(LOCKOUT_PUMP_I),
      .flag_o(lock_pump_f));

   assign lockout = lock_main_f | lock_logic_f | lock_pump_f;
   assign cmd = hbp_cmd_t'({dir_b, dir_a});
   // Only forward and reverse put current through the sense resistor from the supply.
   assign drive_on = (cmd == HBP_FWD) || (cmd == HBP_REV);

   // Thermal cutout latches until the release flag says the die has cooled.
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         thermal_cutout_r <= 1'b0;
      end else if (therm_on_f) begin
         thermal_cutout_r <= 1'b1;
      end else if (therm_off_f) begin
         thermal_cutout_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         cmd_prev_r <= HBP_COAST;
      end else begin
         cmd_prev_r <= cmd;
      end
   end

   // A new drive phase begun in the run state, including each host phase pulse, restarts blanking.
   assign turn_on = drive_on && (cmd != cmd_prev_r);
   // With the limit first, the guard is looked at only while blanking hides the limit.
   assign guard_hit = guard_f && drive_on &&
      (guard_below_f || state_r == HBP_BLANK);
   assign tmr_done = (tmr_r == '0);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         HBP_RUN: begin
            if (guard_hit) begin
               state_nxt = HBP_GUARD_OFF;
            end else if (turn_on) begin
               state_nxt = HBP_BLANK;
            end else if (drive_on && limit_f && !guard_below_f) begin
               state_nxt = HBP_LIMIT_OFF;
            end else if (drive_on && limit_f) begin
               state_nxt = HBP_LIMIT_OFF;
            end
         end
         HBP_BLANK: begin
            if (guard_hit) begin
               state_nxt = HBP_GUARD_OFF;
            end else if (!drive_on) begin
               state_nxt = HBP_RUN;
            end else if (tmr_done) begin
               state_nxt = HBP_RUN;
            end
         end
         HBP_LIMIT_OFF: begin
            if (guard_f && guard_below_f) begin
               state_nxt = HBP_GUARD_OFF;
            end else if (tmr_done) begin
               state_nxt = HBP_BLANK;
            end
         end
         HBP_GUARD_OFF: begin
            if (tmr_done) begin
               state_nxt = HBP_BLANK;
            end
         end
      endcase
      if (lockout || thermal_cutout_r) begin
         state_nxt = HBP_RUN;
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= HBP_RUN;
         tmr_r <= '0;
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r || (state_r == HBP_RUN && turn_on)) begin
            unique case (state_nxt)
               HBP_BLANK: tmr_r <= CNT_W'(BLANK_CYC - 1);
               HBP_LIMIT_OFF: tmr_r <= CNT_W'(LIMIT_OFF_CYC - 1);
               HBP_GUARD_OFF: tmr_r <= CNT_W'(GUARD_OFF_CYC - 1);
               HBP_RUN: tmr_r <= '0;
            endcase
         end else if (!tmr_done) begin
            tmr_r <= tmr_r - CNT_W'(1);
         end
      end
   end

   // Counts the cycles spent in the guard off period, so its full length can be checked.
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         guard_len_r <= '0;
      end else if (state_r == HBP_GUARD_OFF) begin
         guard_len_r <= guard_len_r + CNT_W'(1);
      end else begin
         guard_len_r <= '0;
      end
   end

   // Switch pattern {a_hi, a_lo, b_hi, b_lo}.
   always_comb begin
      unique case (cmd)
         HBP_COAST: sw_nxt = 4'h0;
         HBP_FWD: sw_nxt = 4'h9;
         HBP_REV: sw_nxt = 4'h6;
         HBP_BRAKE: sw_nxt = 4'h5;
      endcase
      // In the limit off time, the high-side is masked off and the driven low-side stays on for recirculation.
      if (state_r == HBP_LIMIT_OFF) begin
         sw_nxt = sw_nxt & 4'h5;
      end
      if (state_r == HBP_GUARD_OFF || lockout || thermal_cutout_r) begin
         sw_nxt = 4'h0;
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         BRIDGE_OUT_A_HI_O <= 1'b0;
         BRIDGE_OUT_A_LO_O <= 1'b0;
         BRIDGE_OUT_B_HI_O <= 1'b0;
         BRIDGE_OUT_B_LO_O <= 1'b0;
      end else begin
         BRIDGE_OUT_A_HI_O <= sw_nxt[3];
         BRIDGE_OUT_A_LO_O <= sw_nxt[2];
         BRIDGE_OUT_B_HI_O <= sw_nxt[1];
         BRIDGE_OUT_B_LO_O <= sw_nxt[0];
      end
   end

   // The toggle runs free, so it is not aligned with the off-time edges.
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         diag_cnt_r <= '0;
         diag_tgl_r <= 1'b0;
      end else if (diag_cnt_r == CNT_W'(DIAG_HALF_CYC - 1)) begin
         diag_cnt_r <= '0;
         diag_tgl_r <= ~diag_tgl_r;
      end else begin
         diag_cnt_r <= diag_cnt_r + CNT_W'(1);
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         DIAG_O <= 1'b0;
      end else if (lockout || thermal_cutout_r || state_r == HBP_GUARD_OFF) begin
         DIAG_O <= 1'b0;
      end else if (state_r == HBP_LIMIT_OFF) begin
         DIAG_O <= diag_tgl_r;
      end else begin
         DIAG_O <= 1'b1;
      end
   end

   guard_off_len_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      state_r == HBP_GUARD_OFF && state_nxt != HBP_GUARD_OFF && !lockout
      && !thermal_cutout_r |-> guard_len_r == CNT_W'(GUARD_OFF_CYC - 1))
      else $error("Guard off period has the wrong length.");
   guard_anytime_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      guard_f && guard_below_f && drive_on && !lockout && !thermal_cutout_r
      && state_r != HBP_GUARD_OFF |=> state_r == HBP_GUARD_OFF)
      else $error("Guard did not act while it has priority.");
   guard_all_off_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      state_r == HBP_GUARD_OFF |=> !BRIDGE_OUT_A_HI_O && !BRIDGE_OUT_A_LO_O &&
      !BRIDGE_OUT_B_HI_O && !BRIDGE_OUT_B_LO_O)
      else $error("Switch on during guard off.");
   guard_diag_low_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      state_r == HBP_GUARD_OFF |=> !DIAG_O)
      else $error("Diagnostic not low in guard off.");
   guard_recover_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      state_r == HBP_GUARD_OFF && tmr_done && !lockout && !thermal_cutout_r
      |=> state_r == HBP_BLANK)
      else $error("Guard did not recover.");
   lockout_off_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      lockout |=> !BRIDGE_OUT_A_HI_O && !BRIDGE_OUT_A_LO_O && !BRIDGE_OUT_B_HI_O
      && !BRIDGE_OUT_B_LO_O && !DIAG_O)
      else $error("Bridge active under lockout.");
   thermal_hold_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      thermal_cutout_r && !therm_off_f |=> thermal_cutout_r)
      else $error("Thermal cutout released early.");
   thermal_diag_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      thermal_cutout_r |=> !DIAG_O && !BRIDGE_OUT_A_LO_O)
      else $error("Output active in thermal cutout.");
   limit_hs_off_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      state_r == HBP_LIMIT_OFF |=> !BRIDGE_OUT_A_HI_O && !BRIDGE_OUT_B_HI_O)
      else $error("High side on in limit off.");
   blank_ignore_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      state_r == HBP_BLANK && !guard_hit && !lockout && !thermal_cutout_r && drive_on
      && !tmr_done |=> state_r == HBP_BLANK)
      else $error("Limit acted during blanking.");
   fwd_decode_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      cmd == HBP_FWD && state_r != HBP_GUARD_OFF && state_r != HBP_LIMIT_OFF && !lockout
      && !thermal_cutout_r |=> BRIDGE_OUT_A_HI_O && BRIDGE_OUT_B_LO_O)
      else $error("Forward decode wrong.");
endmodule
`default_nettype wire

// ===== testbench/hbp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Behaves as the host controller that sets the two direction inputs.
module hbp_host_model
   import hbp_pkg::*;
#(
   parameter int unsigned PERIOD_CYC = 6250, // 40 kHz pulse rate.
   parameter int unsigned FAST_ON_CYC = 4000, // Above half a period.
   parameter int unsigned SLOW_ON_CYC = 2250 // Below half a period.
)(
   input wire logic clk_i, // Clock.
   input wire logic [1:0] mode_i, // 0 steady, 1 fast decay, 2 slow decay.
   input wire logic [1:0] code_i, // Steady levels {b,a}.
   input wire logic rev_i, // Pulse input b instead of input a.
   input wire logic glitch_i, // Inverts input a while high, steady mode only.
   output logic dir_a_o, // Direction input a.
   output logic dir_b_o // Direction input b.
);
   logic [12:0] cnt_r;
   logic pulse;
   logic steady;
   assign pulse = (mode_i == 2'h1) ? (cnt_r < FAST_ON_CYC) : (cnt_r < SLOW_ON_CYC);
   // Slow decay recirculates in brake, fast decay in coast with the steady input low.
   assign steady = (mode_i == 2'h2);
   always_ff @(posedge clk_i) begin
      cnt_r <= (mode_i == 2'h0 || cnt_r == PERIOD_CYC - 1) ? 13'h0 : cnt_r + 13'h1;
   end
   always_ff @(posedge clk_i) begin
      if (mode_i == 2'h0) begin
         dir_a_o <= code_i[0] ^ glitch_i;
         dir_b_o <= code_i[1];
      end else begin
         dir_a_o <= rev_i ? steady : pulse;
         dir_b_o <= rev_i ? pulse : steady;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/test_hbp_bridge_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
   $display("unexpected %s: expected %h seen %h", nm, ex, got); err_count++; end end
module test_hbp_bridge_ctrl;
   import hbp_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, lim = 1'b0, oc = 1'b0, gbl = 1'b1;
   logic th_on = 1'b0, th_off = 1'b0, rev = 1'b0, glitch = 1'b0, pd;
   logic [2:0] lock = 3'h0;
   logic [1:0] mode = 2'h0, code = 2'h0;
   logic dir_a, dir_b, a_hi, a_lo, b_hi, b_lo, diag;
   wire logic [4:0] obs = {a_hi, a_lo, b_hi, b_lo, diag};
   int err_count = 0, n_compared = 0, n, k, t;
   // Each row is {b,a} followed by the expected {a_hi,a_lo,b_hi,b_lo,diag}.
   logic [6:0] rows [6] = '{7'h33, 7'h4D, 7'h6B, 7'h01, 7'h4D, 7'h33};
   always #2 clk = ~clk;
   hbp_host_model hbp_host_model_i (.clk_i(clk), .mode_i(mode), .code_i(code), .rev_i(rev),
      .glitch_i(glitch), .dir_a_o(dir_a), .dir_b_o(dir_b));
   hbp_bridge_ctrl hbp_bridge_ctrl_i (.CLK_I(clk), .ARST_N_I(arst_n), .DIR_INPUT_A_I(dir_a),
      .DIR_INPUT_B_I(dir_b), .LIMIT_CMP_I(lim), .OVERCURRENT_CMP_I(oc),
      .GUARD_BELOW_LIMIT_I(gbl), .THERMAL_ON_I(th_on), .THERMAL_OFF_I(th_off),
      .LOCKOUT_MAIN_I(lock[0]), .LOCKOUT_LOGIC_I(lock[1]), .LOCKOUT_PUMP_I(lock[2]),
      .BRIDGE_OUT_A_HI_O(a_hi), .BRIDGE_OUT_A_LO_O(a_lo), .BRIDGE_OUT_B_HI_O(b_hi),
      .BRIDGE_OUT_B_LO_O(b_lo), .DIAG_O(diag));
   task automatic cyc(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic finish_test;
      if (err_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Bounded wait for the side A high switch to reach lvl; n returns the cycles spent.
   task automatic wait_hi(input logic lvl, input int bound);
      n = 0;
      while (a_hi !== lvl && n < bound) begin
         cyc(1);
         n++;
      end
      if (a_hi !== lvl) begin
         `CHK("a_hi wait", lvl, a_hi)
         finish_test();
      end
   endtask
   initial begin
      cyc(2);
      `CHK("reset obs", 5'h00, obs)
      cyc(2);
      arst_n <= 1'b1;
      cyc(10);
      for (k = 0; k < 6; k++) begin
         code <= rows[k][6:5];
         cyc(100);
         `CHK("decode", rows[k][4:0], obs)
      end
      // A pulse shorter than the filter time must not leave forward drive.
      glitch <= 1'b1;
      cyc(40);
      glitch <= 1'b0;
      cyc(100);
      `CHK("glitch", 5'h13, obs)
      for (k = 0; k < 3; k++) begin
         lock[k] <= 1'b1;
         cyc(10);
         `CHK("lockout", 5'h00, obs)
         lock[k] <= 1'b0;
         cyc(10);
         `CHK("lockout clear", 5'h13, obs)
      end
      // The activation flag drops before the release flag: outputs stay off meanwhile.
      th_on <= 1'b1;
      cyc(10);
      th_on <= 1'b0;
      cyc(50);
      `CHK("thermal hold", 5'h00, obs)
      th_off <= 1'b1;
      cyc(20);
      th_off <= 1'b0;
      `CHK("thermal release", 5'h13, obs)
      // The host sees each overcurrent on the diagnostic pin and simply drives again.
      for (k = 0; k < 2; k++) begin
         gbl <= (k == 0);
         code <= 2'h0;
         cyc(100);
         code <= 2'h1;
         wait_hi(1'b1, 200);
         if (k == 0) begin
            cyc(2000);
         end
         oc <= 1'b1;
         wait_hi(1'b0, 20);
         oc <= 1'b0;
         cyc(5);
         `CHK("guard off", 5'h00, obs)
         wait_hi(1'b1, GUARD_OFF_CYC + 100);
         `CHK("guard time", 1'b1, (n >= GUARD_OFF_CYC - 30 && n <= GUARD_OFF_CYC + 5))
         cyc(5);
         `CHK("guard recover", 5'h13, obs)
      end
      code <= 2'h0;
      cyc(100);
      code <= 2'h1;
      wait_hi(1'b1, 200);
      lim <= 1'b1;
      cyc(BLANK_CYC - 60);
      `CHK("blank ignores limit", 1'b1, a_hi)
      wait_hi(1'b0, 80);
      lim <= 1'b0;
      oc <= 1'b1;
      cyc(5);
      `CHK("limit off sides", 4'h1, obs[4:1])
      t = 0;
      pd = diag;
      for (k = 0; k < 4 * DIAG_HALF_CYC; k++) begin
         cyc(1);
         if (diag !== pd) begin
            t++;
         end
         pd = diag;
      end
      oc <= 1'b0;
      `CHK("diag toggles", 1'b1, (t >= 3 && t <= 5))
      wait_hi(1'b1, LIMIT_OFF_CYC);
      t = n + 4 * DIAG_HALF_CYC + 5;
      `CHK("limit off time", 1'b1, (t >= LIMIT_OFF_CYC - 20 && t <= LIMIT_OFF_CYC + 10))
      for (k = 1; k < 3; k++) begin
         mode <= 2'h0;
         code <= 2'h0;
         cyc(100);
         mode <= k[1:0];
         rev <= (k == 2);
         cyc(1500);
         `CHK("pwm on", (k == 1) ? 5'h13 : 5'h0B, obs)
         cyc(3500);
         `CHK("pwm off", (k == 1) ? 5'h01 : 5'h13, obs)
      end
      // A reset in mid-run drops everything, and the held forward level is taken again.
      mode <= 2'h0;
      rev <= 1'b0;
      code <= 2'h1;
      arst_n <= 1'b0;
      cyc(3);
      `CHK("midrun reset obs", 5'h00, obs)
      arst_n <= 1'b1;
      cyc(2);
      `CHK("midrun release obs", 5'h00, obs)
      cyc(100);
      `CHK("midrun decode", 5'h13, obs)
      finish_test();
   end
endmodule
`default_nettype wire
